// ### gpio_port_map.vh
// register offsets, reset values and field positions of the 8-bit gpio port
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH
// ==========================================================
// word offsets (byte addresses) on the wishbone bus
`define OFS_DATA_LATCH 4'h0
`define OFS_DIRECTION 4'h4
`define OFS_PULLUP 4'h8
`define OFS_STANDBY 4'hc
// ==========================================================
// reset values
`define RST_DATA_LATCH 8'h00
`define RST_DIRECTION 8'h00
`define RST_PULLUP 8'h00
`define RST_STANDBY 8'h00
// ==========================================================
// field positions
`define BIT_PIN_STATE 0
`define BIT_NO_PULLUP 2
`define BIT_PIN_FOUR 4
`define BIT_PIN_SIX 6
// ==========================================================
// pins that are open drain (mask)
`define OPEN_DRAIN_MASK 8'h00
`endif

// ### gpio_pin_cell.v
// one pad cell of the port: drive, pull-up and input blocking
`timescale 1ns/10ps
module gpio_pin_cell #(
  parameter OPEN_DRAIN = 0,
  parameter HAS_PULLUP = 1,
  parameter WAKE_CAPABLE = 0
) (
  // configuration
  input wire dir,
  input wire latch,
  input wire pull_en,
  // peripheral
  input wire periph_oe,
  input wire periph_out,
  // standby
  input wire force_hiz,
  input wire wake_en,
  // pad
  input wire pad_in,
  output wire pad_out,
  output wire pad_oe,
  output wire pad_pull,
  output wire pin_level,
  output wire core_in
);
  wire drv_val;
  wire drv_en;
  wire blocked;
  // ==========================================================
  // drive path
  assign drv_val = periph_oe ? periph_out : latch;
  assign drv_en = (periph_oe | dir) & ~force_hiz;
  // open drain releases high instead of driving it
  assign pad_out = drv_val;
  assign pad_oe = drv_en & ~(OPEN_DRAIN != 0 && drv_val);
  // low output always cuts the pull-up
  assign pad_pull = (HAS_PULLUP != 0) & pull_en & ~(drv_en & ~drv_val);
  // ==========================================================
  // input path; wake pins with wake_en set stay open during forced standby
  assign blocked = force_hiz & ~((WAKE_CAPABLE != 0) & wake_en);
  assign core_in = blocked ? 1'b0 : pad_in;
  // pin level seen by reads: driven value or pad
  assign pin_level = pad_oe ? drv_val : pad_in;
endmodule // gpio_pin_cell

// ### gpio_port.v
// 8-bit gpio port with direction, data latch, pull-up and standby control
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "gpio_port_map.vh"
module gpio_port #(
  parameter [7:0] OPEN_DRAIN = `OPEN_DRAIN_MASK
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RESET,
  // wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [3:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire RMW_QUALIFIER,
  output reg [31:0] WB_DAT_O,
  output wire WB_ACK_O,
  output wire WB_ERR_O,
  // power mode and interrupt enables
  input wire STOP_OR_WATCH,
  input wire PIN_FOUR_IRQ_EN,
  input wire PIN_SIX_IRQ_EN,
  // peripherals
  input wire [7:0] PERIPH_OE,
  input wire [7:0] PERIPH_OUT,
  output wire [7:0] PERIPH_IN,
  // pads
  input wire [7:0] PAD_IN,
  output wire [7:0] PAD_OUT,
  output wire [7:0] PAD_OE,
  output wire [7:0] PAD_PULLUP
);
  reg [7:0] latch_q;
  reg [7:0] dir_q;
  reg [7:0] pull_q;
  reg [7:0] stby_q;
  reg ack_q;
  reg [31:0] rdat_d;
  reg hit_d;
  reg [7:0] hold_oe_q;
  reg [7:0] hold_out_q;
  reg in_standby_q;
  wire [7:0] pin_level;
  wire [7:0] cell_oe;
  wire [7:0] cell_out;
  wire [7:0] port_read;
  wire req;
  wire force_hiz;
  wire [7:0] wake_en;
  wire [2:0] sel_idx;

  // ==========================================================
  // address decode; read mux and write path share one decoder
  localparam [2:0] REG_DATA = 3'h0;
  localparam [2:0] REG_DIR = 3'h1;
  localparam [2:0] REG_PULL = 3'h2;
  localparam [2:0] REG_STBY = 3'h3;
  localparam [2:0] REG_NONE = 3'h4;

  function [2:0] reg_index;
    input [3:0] adr;
    begin
      case (adr)
        `OFS_DATA_LATCH: reg_index = REG_DATA;
        `OFS_DIRECTION: reg_index = REG_DIR;
        `OFS_PULLUP: reg_index = REG_PULL;
        `OFS_STANDBY: reg_index = REG_STBY;
        default: reg_index = REG_NONE;
      endcase
    end
  endfunction

  assign sel_idx = reg_index(WB_ADR_I);

  // ==========================================================
  // bus decode
  // one wait state: ack comes one edge after the request is seen
  assign req = WB_CYC_I & WB_STB_I & ~ack_q;

  always @* begin
    hit_d = 1'b1;
    rdat_d = 32'h00000000;
    case (sel_idx)
      REG_DATA: rdat_d = {24'h000000, port_read};
      REG_DIR: rdat_d = {24'h000000, dir_q};
      REG_PULL: rdat_d = {24'h000000, pull_q};
      REG_STBY: rdat_d = {24'h000000, stby_q};
      default: hit_d = 1'b0;
    endcase
  end

  // without RMW_QUALIFIER, input pins and peripheral-driven pins read the pin, others the latch
  assign port_read = RMW_QUALIFIER ? latch_q :
    ((dir_q & ~PERIPH_OE & latch_q) | (~(dir_q & ~PERIPH_OE) & pin_level));

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      ack_q <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      ack_q <= req & hit_d;
      WB_DAT_O <= (req & hit_d & ~WB_WE_I) ? rdat_d : 32'h00000000;
    end
  end

  reg err_q;
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      err_q <= 1'b0;
    end else begin
      err_q <= WB_CYC_I & WB_STB_I & ~err_q & ~ack_q & ~hit_d;
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_ERR_O = err_q;

  // ==========================================================
  // registers; only byte lane 0 holds data
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      latch_q <= `RST_DATA_LATCH;
      dir_q <= `RST_DIRECTION;
      pull_q <= `RST_PULLUP;
      stby_q <= `RST_STANDBY;
    end else if (req & hit_d & WB_WE_I & WB_SEL_I[0]) begin
      case (sel_idx)
        REG_DATA: latch_q <= WB_DAT_I[7:0];
        REG_DIR: dir_q <= WB_DAT_I[7:0];
        REG_PULL: pull_q <= WB_DAT_I[7:0];
        REG_STBY: stby_q <= {7'h00, WB_DAT_I[`BIT_PIN_STATE]};
        default: stby_q <= stby_q;
      endcase
    end
  end

  // ==========================================================
  // standby: freeze peripheral drive state on entry, used when the bit is clear
  // freezing avoids glitches if peripherals change PERIPH_OE or PERIPH_OUT while stopping
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      in_standby_q <= 1'b0;
      hold_oe_q <= 8'h00;
      hold_out_q <= 8'h00;
    end else begin
      in_standby_q <= STOP_OR_WATCH;
      if (STOP_OR_WATCH & ~in_standby_q) begin
        hold_oe_q <= PERIPH_OE;
        hold_out_q <= PERIPH_OUT;
      end
    end
  end

  assign force_hiz = STOP_OR_WATCH & stby_q[`BIT_PIN_STATE];
  // peripheral state kept through standby with bit clear
  assign cell_oe = (STOP_OR_WATCH & in_standby_q) ? hold_oe_q : PERIPH_OE;
  assign cell_out = (STOP_OR_WATCH & in_standby_q) ? hold_out_q : PERIPH_OUT;
  assign wake_en = {1'b0, PIN_SIX_IRQ_EN, 1'b0, PIN_FOUR_IRQ_EN, 4'h0};

  // ==========================================================
  // pin cells, bit n to pin n
  gpio_pin_cell #(
    .OPEN_DRAIN(OPEN_DRAIN[0]),
    .HAS_PULLUP(0 != `BIT_NO_PULLUP),
    .WAKE_CAPABLE(0 == `BIT_PIN_FOUR || 0 == `BIT_PIN_SIX)
  ) u_pin0 (
    .dir(dir_q[0]),
    .latch(latch_q[0]),
    .pull_en(pull_q[0]),
    .periph_oe(cell_oe[0]),
    .periph_out(cell_out[0]),
    .force_hiz(force_hiz),
    .wake_en(wake_en[0]),
    .pad_in(PAD_IN[0]),
    .pad_out(PAD_OUT[0]),
    .pad_oe(PAD_OE[0]),
    .pad_pull(PAD_PULLUP[0]),
    .pin_level(pin_level[0]),
    .core_in(PERIPH_IN[0])
  );

  gpio_pin_cell #(
    .OPEN_DRAIN(OPEN_DRAIN[1]),
    .HAS_PULLUP(1 != `BIT_NO_PULLUP),
    .WAKE_CAPABLE(1 == `BIT_PIN_FOUR || 1 == `BIT_PIN_SIX)
  ) u_pin1 (
    .dir(dir_q[1]),
    .latch(latch_q[1]),
    .pull_en(pull_q[1]),
    .periph_oe(cell_oe[1]),
    .periph_out(cell_out[1]),
    .force_hiz(force_hiz),
    .wake_en(wake_en[1]),
    .pad_in(PAD_IN[1]),
    .pad_out(PAD_OUT[1]),
    .pad_oe(PAD_OE[1]),
    .pad_pull(PAD_PULLUP[1]),
    .pin_level(pin_level[1]),
    .core_in(PERIPH_IN[1])
  );

  // pin two has no pull-up; its register bit is plain storage
  gpio_pin_cell #(
    .OPEN_DRAIN(OPEN_DRAIN[2]),
    .HAS_PULLUP(2 != `BIT_NO_PULLUP),
    .WAKE_CAPABLE(2 == `BIT_PIN_FOUR || 2 == `BIT_PIN_SIX)
  ) u_pin2 (
    .dir(dir_q[2]),
    .latch(latch_q[2]),
    .pull_en(pull_q[2]),
    .periph_oe(cell_oe[2]),
    .periph_out(cell_out[2]),
    .force_hiz(force_hiz),
    .wake_en(wake_en[2]),
    .pad_in(PAD_IN[2]),
    .pad_out(PAD_OUT[2]),
    .pad_oe(PAD_OE[2]),
    .pad_pull(PAD_PULLUP[2]),
    .pin_level(pin_level[2]),
    .core_in(PERIPH_IN[2])
  );

  gpio_pin_cell #(
    .OPEN_DRAIN(OPEN_DRAIN[3]),
    .HAS_PULLUP(3 != `BIT_NO_PULLUP),
    .WAKE_CAPABLE(3 == `BIT_PIN_FOUR || 3 == `BIT_PIN_SIX)
  ) u_pin3 (
    .dir(dir_q[3]),
    .latch(latch_q[3]),
    .pull_en(pull_q[3]),
    .periph_oe(cell_oe[3]),
    .periph_out(cell_out[3]),
    .force_hiz(force_hiz),
    .wake_en(wake_en[3]),
    .pad_in(PAD_IN[3]),
    .pad_out(PAD_OUT[3]),
    .pad_oe(PAD_OE[3]),
    .pad_pull(PAD_PULLUP[3]),
    .pin_level(pin_level[3]),
    .core_in(PERIPH_IN[3])
  );

  // pins four and six can wake the device, so their input stays open while their irq enable is set
  gpio_pin_cell #(
    .OPEN_DRAIN(OPEN_DRAIN[4]),
    .HAS_PULLUP(4 != `BIT_NO_PULLUP),
    .WAKE_CAPABLE(4 == `BIT_PIN_FOUR || 4 == `BIT_PIN_SIX)
  ) u_pin4 (
    .dir(dir_q[4]),
    .latch(latch_q[4]),
    .pull_en(pull_q[4]),
    .periph_oe(cell_oe[4]),
    .periph_out(cell_out[4]),
    .force_hiz(force_hiz),
    .wake_en(wake_en[4]),
    .pad_in(PAD_IN[4]),
    .pad_out(PAD_OUT[4]),
    .pad_oe(PAD_OE[4]),
    .pad_pull(PAD_PULLUP[4]),
    .pin_level(pin_level[4]),
    .core_in(PERIPH_IN[4])
  );

  gpio_pin_cell #(
    .OPEN_DRAIN(OPEN_DRAIN[5]),
    .HAS_PULLUP(5 != `BIT_NO_PULLUP),
    .WAKE_CAPABLE(5 == `BIT_PIN_FOUR || 5 == `BIT_PIN_SIX)
  ) u_pin5 (
    .dir(dir_q[5]),
    .latch(latch_q[5]),
    .pull_en(pull_q[5]),
    .periph_oe(cell_oe[5]),
    .periph_out(cell_out[5]),
    .force_hiz(force_hiz),
    .wake_en(wake_en[5]),
    .pad_in(PAD_IN[5]),
    .pad_out(PAD_OUT[5]),
    .pad_oe(PAD_OE[5]),
    .pad_pull(PAD_PULLUP[5]),
    .pin_level(pin_level[5]),
    .core_in(PERIPH_IN[5])
  );

  gpio_pin_cell #(
    .OPEN_DRAIN(OPEN_DRAIN[6]),
    .HAS_PULLUP(6 != `BIT_NO_PULLUP),
    .WAKE_CAPABLE(6 == `BIT_PIN_FOUR || 6 == `BIT_PIN_SIX)
  ) u_pin6 (
    .dir(dir_q[6]),
    .latch(latch_q[6]),
    .pull_en(pull_q[6]),
    .periph_oe(cell_oe[6]),
    .periph_out(cell_out[6]),
    .force_hiz(force_hiz),
    .wake_en(wake_en[6]),
    .pad_in(PAD_IN[6]),
    .pad_out(PAD_OUT[6]),
    .pad_oe(PAD_OE[6]),
    .pad_pull(PAD_PULLUP[6]),
    .pin_level(pin_level[6]),
    .core_in(PERIPH_IN[6])
  );

  gpio_pin_cell #(
    .OPEN_DRAIN(OPEN_DRAIN[7]),
    .HAS_PULLUP(7 != `BIT_NO_PULLUP),
    .WAKE_CAPABLE(7 == `BIT_PIN_FOUR || 7 == `BIT_PIN_SIX)
  ) u_pin7 (
    .dir(dir_q[7]),
    .latch(latch_q[7]),
    .pull_en(pull_q[7]),
    .periph_oe(cell_oe[7]),
    .periph_out(cell_out[7]),
    .force_hiz(force_hiz),
    .wake_en(wake_en[7]),
    .pad_in(PAD_IN[7]),
    .pad_out(PAD_OUT[7]),
    .pad_oe(PAD_OE[7]),
    .pad_pull(PAD_PULLUP[7]),
    .pin_level(pin_level[7]),
    .core_in(PERIPH_IN[7])
  );
endmodule // gpio_port

// ### gpio_port_assertions.sv
// bus and pad checker for the gpio port
`timescale 1ns/10ps
// ==========================================================
module gpio_port_chk (
  input wire CLK_SYS, RESET, WB_CYC_I, WB_STB_I, WB_ACK_O, WB_ERR_O, STOP_OR_WATCH,
  input wire [3:0] WB_ADR_I,
  input wire [7:0] PAD_OE, PAD_OUT, PAD_PULLUP, PERIPH_OE, PERIPH_OUT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  a_err_once: assert property (WB_ERR_O |=> !WB_ERR_O) else $error("err held");
  a_req_answer: assert property (req |=> WB_ACK_O || WB_ERR_O) else $error("no answer");
  a_err_unmapped: assert property (req && WB_ADR_I[1:0] != 2'h0 |=> WB_ERR_O && !WB_ACK_O)
    else $error("unmapped acked");
  a_pull_bit2: assert property (!PAD_PULLUP[2]) else $error("pin two pulled");
  a_pull_low: assert property ((PAD_PULLUP & PAD_OE & ~PAD_OUT) == 8'h00)
    else $error("pull on low pin");
  // peripheral route checked only outside standby, where freezing may apply
  a_periph_route: assert property (!STOP_OR_WATCH |->
    ((PERIPH_OE & ~PAD_OE) | (PERIPH_OE & (PAD_OUT ^ PERIPH_OUT))) == 8'h00) else $error("route");
  a_reset_dir: assert property (disable iff (1'b0) RESET |=> (PAD_OE & ~PERIPH_OE) == 8'h00)
    else $error("pin driven after reset");
endmodule // gpio_port_chk
bind gpio_port gpio_port_chk chk_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .STOP_OR_WATCH(STOP_OR_WATCH),
  .WB_ADR_I(WB_ADR_I), .PAD_OE(PAD_OE), .PAD_OUT(PAD_OUT), .PAD_PULLUP(PAD_PULLUP),
  .PERIPH_OE(PERIPH_OE), .PERIPH_OUT(PERIPH_OUT));

// ### gpio_pad_board.sv
// board-side model of the eight pads
`timescale 1ns/10ps
// ==========================================================
module gpio_pad_board (
  input wire clk,
  input wire [7:0] oe, drv, pull, ext_en, ext_val,
  output logic [7:0] pin
);
  logic [7:0] flt_q = 8'h00;
  // lines nobody drives or pulls up toggle, so a stale level never passes for a read
  always @(posedge clk) flt_q <= ~pin;
  always_comb pin = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull | flt_q));
endmodule // gpio_pad_board

// ### gpio_port_tb.sv
// self-checking bench for the gpio port
`timescale 1ns/10ps
// ==========================================================
module gpio_port_tb;
  logic CLK_SYS = 1'b0, RESET = 1'b1, cyc = 0, stb = 0, we = 0, read_modify_write_qualifier = 0, stop = 0, irq4 = 0;
  logic irq6 = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, s = 32'h65f1, WB_DAT_O;
  logic [7:0] po = 0, pv = 0, ext_en = 0, ext_val = 0, r, d, p, o, m, eo, lvl;
  logic [7:0] PERIPH_IN, PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP;
  logic WB_ACK_O, WB_ERR_O;
  logic [32:0] q[$];
  int failures = 0, samples_checked = 0, cnt = 0;
  always #12.5 CLK_SYS = ~CLK_SYS;
  gpio_port dut_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .RMW_QUALIFIER(read_modify_write_qualifier), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .STOP_OR_WATCH(stop), .PIN_FOUR_IRQ_EN(irq4),
    .PIN_SIX_IRQ_EN(irq6), .PERIPH_OE(po), .PERIPH_OUT(pv), .PERIPH_IN(PERIPH_IN),
    .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .PAD_PULLUP(PAD_PULLUP));
  gpio_pad_board pad_u (.clk(CLK_SYS), .oe(PAD_OE), .drv(PAD_OUT), .pull(PAD_PULLUP),
    .ext_en(ext_en), .ext_val(ext_val), .pin(PAD_IN));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [32:0] g, e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v, input logic k,
    input logic [32:0] e);
    q.push_back(e);
    @(posedge CLK_SYS);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    read_modify_write_qualifier <= k;
    do @(posedge CLK_SYS); while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge CLK_SYS) if (WB_ACK_O === 1'b1 || WB_ERR_O === 1'b1)
    chk({WB_ERR_O, WB_DAT_O}, q.pop_front());
  always @(posedge CLK_SYS) begin
    cnt++;
    if (cnt == 3000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RESET <= 1'b0;
    wb(0, 4'h4, 8'h0, 0, 33'h0);
    for (int i = 0; i < 6; i++) begin
      repeat (32) s = lfsr(s);
      r = s[7:0];
      d = s[15:8];
      p = s[23:16];
      o = i[0] ? s[27:20] : 8'h00;
      @(posedge CLK_SYS);
      po <= o;
      pv <= ~r;
      ext_en <= ~(d | o);
      ext_val <= s[31:24];
      wb(1, 4'h0, r, 0, 33'h0);
      wb(1, 4'h4, d, 0, 33'h0);
      wb(1, 4'h8, p, 0, 33'h0);
      @(negedge CLK_SYS);
      m = d | o;
      eo = o ^ r;
      lvl = (m & eo) | (~m & s[31:24]);
      chk(33'(PAD_OE), 33'(m));
      chk(33'(PAD_OUT & m), 33'(m & eo));
      chk(33'(PAD_PULLUP), 33'(p & 8'hfb & ~(m & ~eo)));
      chk(33'(PERIPH_IN), 33'(lvl));
      wb(0, 4'h0, 8'h0, 0, 33'(lvl));
      wb(0, 4'h0, 8'h0, 1, 33'(r));
      wb(0, 4'h8, 8'h0, 0, 33'(p));
      $display("test %0d done", i);
    end
    @(posedge CLK_SYS);
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    stop <= 1'b1;
    irq4 <= 1'b1;
    @(posedge CLK_SYS);
    po <= ~o;
    pv <= r;
    @(negedge CLK_SYS);
    chk(33'(PAD_OE), 33'(m));
    chk(33'(PAD_OUT & m), 33'(m & eo));
    wb(1, 4'hc, 8'h01, 0, 33'h0);
    @(negedge CLK_SYS);
    chk(33'(PAD_OE), 33'h0);
    chk(33'(PERIPH_IN), 33'h10);
    @(posedge CLK_SYS);
    irq6 <= 1'b1;
    @(negedge CLK_SYS);
    chk(33'(PERIPH_IN), 33'h50);
    wb(0, 4'h2, 8'h0, 0, {1'b1, 32'h0});
    $display("standby test done");
    end_sim();
  end
endmodule // gpio_port_tb
